// *** verilog/lmxt_exec.v ***
`timescale 1ns/1ps
`include "lmxt_map.vh"
// Operation
// - Byte register AND/OR/XOR: 2/1 states
// - Word immediate logic: 5B/4st, 4B/3st
// - Zero and invert accumulator, one state
// - Four accumulator rotates, one state each
// - Nibble swap takes two states
// - Arithmetic right shift keeps sign bit
// - Logical shifts zero fill, 2/1 states
// - Port direct byte read/move adds one
// - Logic write-back to port adds two
// - Data pointer load: 3 bytes, 2 states
// - Doubleword immediate zero/one extended, 5/4
// - Legacy external moves use page register
// - Displaced indirect byte load: 6/5 states
// - Doubleword direct store: 7/6 states
// - Direct to direct move: 3 states
module lmxt_exec
#(
  parameter DW = 32
)
(
  // Clock and reset
  input  wire          I_CLK_SYS,
  input  wire          I_SYS_RST,
  // Configuration
  input  wire          I_SRC_MODE,
  // Request
  input  wire          I_START,
  input  wire [4:0]    I_OP,
  input  wire          I_WORD,
  input  wire [DW-1:0] I_OPND_A,
  input  wire [DW-1:0] I_OPND_B,
  input  wire          I_CARRY,
  input  wire [7:0]    I_DIR_ADDR,
  input  wire [15:0]   I_XADDR,
  input  wire          I_PAGE_WR,
  input  wire [7:0]    I_PAGE_DATA,
  // Answer
  output wire          O_BUSY,
  output reg           O_DONE,
  output reg  [DW-1:0] O_RESULT,
  output reg           O_CARRY,
  output reg  [3:0]    O_BYTES,
  output reg  [3:0]    O_STATES,
  output reg  [23:0]   O_XADDR
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Ports sit on a fixed stride, so a plain range test would also catch the gaps
  function is_port;
    input [7:0] a;
    reg   [7:0] off;
    begin
      off     = a - `LMXT_PORT_LO;
      is_port = (a >= `LMXT_PORT_LO) &&
                (off < `LMXT_PORT_STEP * `LMXT_PORT_N) &&
                ((off % `LMXT_PORT_STEP) == 8'h00);
    end
  endfunction

  wire [3:0] base_bytes;
  wire [3:0] base_states;
  reg        mode_r;
  reg        mode_seen_r;
  reg [7:0]  page_r;
  reg [3:0]  cnt_r;
  reg        busy_r;
  reg [3:0]  extra;
  reg [DW-1:0] res;
  reg        cy;
  // A sum of two 4-bit costs can carry; the widest real total is seven states
  wire [4:0] total_wide;
  wire [3:0] total_states;

  // ****************************************************************
  // Cost lookup
  // ****************************************************************
  lmxt_cost u_cost
  (
    .i_op       (I_OP),
    .i_src_mode (mode_r),
    .o_bytes    (base_bytes),
    .o_states   (base_states)
  );

  // ****************************************************************
  // Port penalty
  // ****************************************************************
  // Only the direct-byte forms pay a penalty; register forms never reach a port
  always @*
  begin
    extra = 4'h0;
    if (is_port(I_DIR_ADDR))
    begin
      case (I_OP)
        `LMXT_OP_AND_DIR, `LMXT_OP_OR_DIR, `LMXT_OP_XOR_DIR:
          extra = `LMXT_PORT_WR_ADD;
        `LMXT_OP_MOV_DD:
          extra = `LMXT_PORT_RD_ADD;
        default:
          extra = 4'h0;
      endcase
    end
  end

  // ****************************************************************
  // Data path
  // ****************************************************************

  always @*
  begin
    res = I_OPND_A;
    cy  = I_CARRY;
    case (I_OP)
      `LMXT_OP_AND_BR, `LMXT_OP_AND_WI, `LMXT_OP_AND_DIR:
        res = I_OPND_A & I_OPND_B;
      `LMXT_OP_OR_BR, `LMXT_OP_OR_WI, `LMXT_OP_OR_DIR:
        res = I_OPND_A | I_OPND_B;
      `LMXT_OP_XOR_BR, `LMXT_OP_XOR_WI, `LMXT_OP_XOR_DIR:
        res = I_OPND_A ^ I_OPND_B;
      // Accumulator-only forms work on the low byte and clear the rest
      `LMXT_OP_ZERO_ACC:
        res = {DW{1'b0}};
      `LMXT_OP_INV_ACC:
        res = {{(DW-8){1'b0}}, ~I_OPND_A[7:0]};
      `LMXT_OP_ROL:
        res = {{(DW-8){1'b0}}, I_OPND_A[6:0], I_OPND_A[7]};
      `LMXT_OP_ROLC:
      begin
        res = {{(DW-8){1'b0}}, I_OPND_A[6:0], I_CARRY};
        cy  = I_OPND_A[7];
      end
      `LMXT_OP_ROR:
        res = {{(DW-8){1'b0}}, I_OPND_A[0], I_OPND_A[7:1]};
      `LMXT_OP_RORC:
      begin
        res = {{(DW-8){1'b0}}, I_CARRY, I_OPND_A[7:1]};
        cy  = I_OPND_A[0];
      end
      `LMXT_OP_SWAP:
        res = {{(DW-8){1'b0}}, I_OPND_A[3:0], I_OPND_A[7:4]};
      `LMXT_OP_ASR:
        res = I_WORD ? {{(DW-16){1'b0}}, I_OPND_A[15], I_OPND_A[15:1]}
                     : {{(DW-8){1'b0}}, I_OPND_A[7], I_OPND_A[7:1]};
      `LMXT_OP_LSR:
        res = I_WORD ? {{(DW-16){1'b0}}, 1'b0, I_OPND_A[15:1]}
                     : {{(DW-8){1'b0}}, 1'b0, I_OPND_A[7:1]};
      `LMXT_OP_LSL:
        res = I_WORD ? {{(DW-16){1'b0}}, I_OPND_A[14:0], 1'b0}
                     : {{(DW-8){1'b0}}, I_OPND_A[6:0], 1'b0};
      `LMXT_OP_LD_PTR:
        res = {{(DW-16){1'b0}}, I_OPND_B[15:0]};
      `LMXT_OP_MOV_DZ:
        res = {{(DW-16){1'b0}}, I_OPND_B[15:0]};
      `LMXT_OP_MOV_DO:
        res = {{(DW-16){1'b1}}, I_OPND_B[15:0]};
      `LMXT_OP_MOV_DISP, `LMXT_OP_MOV_DD, `LMXT_OP_ST_DW:
        res = I_OPND_B;
      default:
        res = I_OPND_A;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Busy drops on the edge that raises done, so a new start is taken in the done cycle
  assign O_BUSY = busy_r;
  assign total_wide   = {1'b0, base_states} + {1'b0, extra};
  assign total_states = total_wide[3:0];

  always @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      mode_r      <= 1'b0;
      mode_seen_r <= 1'b0;
      page_r      <= `LMXT_EXT_PAGE_RST;
      cnt_r       <= 4'h0;
      busy_r      <= 1'b0;
      O_DONE      <= 1'b0;
      O_RESULT    <= {DW{1'b0}};
      O_CARRY     <= 1'b0;
      O_BYTES     <= 4'h0;
      O_STATES    <= 4'h0;
      O_XADDR     <= 24'h000000;
    end
    else
    begin
      O_DONE <= 1'b0;
      // Mode is latched once, ahead of any instruction, so it cannot change mid-stream
      if (!mode_seen_r)
      begin
        mode_r      <= I_SRC_MODE;
        mode_seen_r <= 1'b1;
      end
      if (I_PAGE_WR)
        page_r <= I_PAGE_DATA;
      if (busy_r)
      begin
        cnt_r <= cnt_r - `LMXT_CNT_LAST;
        if (cnt_r == `LMXT_CNT_LAST)
        begin
          busy_r <= 1'b0;
          O_DONE <= 1'b1;
        end
      end
      else if (I_START && mode_seen_r)
      begin
        O_RESULT <= res;
        O_CARRY  <= cy;
        O_BYTES  <= base_bytes;
        O_STATES <= total_states;
        if (I_OP == `LMXT_OP_MOV_LEG_X)
          O_XADDR <= {page_r, I_XADDR};
        cnt_r    <= total_states;
        busy_r   <= 1'b1;
      end
    end
  end
endmodule // lmxt_exec

// *** verilog/lmxt_map.vh ***
`ifndef LMXT_MAP_VH
`define LMXT_MAP_VH
// ****************************************************************
// Operation codes
// ****************************************************************
`define LMXT_OP_AND_BR     5'h00
`define LMXT_OP_OR_BR      5'h01
`define LMXT_OP_XOR_BR     5'h02
`define LMXT_OP_AND_WI     5'h03
`define LMXT_OP_OR_WI      5'h04
`define LMXT_OP_XOR_WI     5'h05
`define LMXT_OP_ZERO_ACC   5'h06
`define LMXT_OP_INV_ACC    5'h07
`define LMXT_OP_ROL        5'h08
`define LMXT_OP_ROLC       5'h09
`define LMXT_OP_ROR        5'h0a
`define LMXT_OP_RORC       5'h0b
`define LMXT_OP_SWAP       5'h0c
`define LMXT_OP_ASR        5'h0d
`define LMXT_OP_LSR        5'h0e
`define LMXT_OP_LSL        5'h0f
`define LMXT_OP_LD_PTR     5'h10
`define LMXT_OP_MOV_DZ     5'h11
`define LMXT_OP_MOV_DO     5'h12
`define LMXT_OP_MOV_DISP   5'h13
`define LMXT_OP_ST_DW      5'h14
`define LMXT_OP_MOV_DD     5'h15
`define LMXT_OP_AND_DIR    5'h16
`define LMXT_OP_OR_DIR     5'h17
`define LMXT_OP_XOR_DIR    5'h18
`define LMXT_OP_MOV_LEG_X  5'h19
// ****************************************************************
// Costs and constants
// ****************************************************************
`define LMXT_PORT_LO       8'h80
`define LMXT_PORT_STEP     8'h10
`define LMXT_PORT_N        8'h04
`define LMXT_PORT_RD_ADD   4'h1
`define LMXT_PORT_WR_ADD   4'h2
`define LMXT_EXT_PAGE_RST  8'h01
`define LMXT_CNT_LAST      4'h1
// ****************************************************************
// Byte lengths (B) and base states (S) per form and opcode mode
// ****************************************************************
`define LMXT_B_BR_BIN      4'h3
`define LMXT_B_BR_SRC      4'h2
`define LMXT_S_BR_BIN      4'h2
`define LMXT_S_BR_SRC      4'h1
`define LMXT_B_WI_BIN      4'h5
`define LMXT_B_WI_SRC      4'h4
`define LMXT_S_WI_BIN      4'h4
`define LMXT_S_WI_SRC      4'h3
`define LMXT_B_ACC         4'h1
`define LMXT_S_ACC         4'h1
`define LMXT_B_SWAP        4'h1
`define LMXT_S_SWAP        4'h2
`define LMXT_B_SH_BIN      4'h3
`define LMXT_B_SH_SRC      4'h2
`define LMXT_S_SH_BIN      4'h2
`define LMXT_S_SH_SRC      4'h1
`define LMXT_B_PTR         4'h3
`define LMXT_S_PTR         4'h2
`define LMXT_B_DX_BIN      4'h5
`define LMXT_B_DX_SRC      4'h4
`define LMXT_S_DX_BIN      4'h5
`define LMXT_S_DX_SRC      4'h4
`define LMXT_B_DISP_BIN    4'h5
`define LMXT_B_DISP_SRC    4'h4
`define LMXT_S_DISP_BIN    4'h6
`define LMXT_S_DISP_SRC    4'h5
`define LMXT_B_STDW_BIN    4'h5
`define LMXT_B_STDW_SRC    4'h4
`define LMXT_S_STDW_BIN    4'h7
`define LMXT_S_STDW_SRC    4'h6
`define LMXT_B_DD          4'h3
`define LMXT_S_DD          4'h3
`define LMXT_B_DIR         4'h2
`define LMXT_S_DIR         4'h2
`define LMXT_B_LEG         4'h1
`define LMXT_S_LEG         4'h5
`endif

// *** verilog/lmxt_cost.v ***
`timescale 1ns/1ps
`include "lmxt_map.vh"
// Cost table: bytes and base states per opcode and mode
module lmxt_cost
(
  // Selection
  input  wire [4:0] i_op,
  input  wire       i_src_mode,
  // Cost
  output reg  [3:0] o_bytes,
  output reg  [3:0] o_states
);
  function [3:0] by_mode;
    input       src;
    input [3:0] bin_val;
    input [3:0] src_val;
    begin
      by_mode = src ? src_val : bin_val;
    end
  endfunction

  always @*
  begin
    o_bytes  = `LMXT_B_ACC;
    o_states = `LMXT_S_ACC;
    case (i_op)
      `LMXT_OP_AND_BR, `LMXT_OP_OR_BR, `LMXT_OP_XOR_BR:
      begin
        o_bytes  = by_mode(i_src_mode, `LMXT_B_BR_BIN, `LMXT_B_BR_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_BR_BIN, `LMXT_S_BR_SRC);
      end
      `LMXT_OP_AND_WI, `LMXT_OP_OR_WI, `LMXT_OP_XOR_WI:
      begin
        o_bytes  = by_mode(i_src_mode, `LMXT_B_WI_BIN, `LMXT_B_WI_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_WI_BIN, `LMXT_S_WI_SRC);
      end
      `LMXT_OP_ZERO_ACC, `LMXT_OP_INV_ACC,
      `LMXT_OP_ROL, `LMXT_OP_ROLC, `LMXT_OP_ROR, `LMXT_OP_RORC:
      begin
        o_bytes  = `LMXT_B_ACC;
        o_states = `LMXT_S_ACC;
      end
      `LMXT_OP_SWAP:
      begin
        o_bytes  = `LMXT_B_SWAP;
        o_states = `LMXT_S_SWAP;
      end
      `LMXT_OP_ASR, `LMXT_OP_LSR, `LMXT_OP_LSL:
      begin
        o_bytes  = by_mode(i_src_mode, `LMXT_B_SH_BIN, `LMXT_B_SH_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_SH_BIN, `LMXT_S_SH_SRC);
      end
      `LMXT_OP_LD_PTR:
      begin
        o_bytes  = `LMXT_B_PTR;
        o_states = `LMXT_S_PTR;
      end
      `LMXT_OP_MOV_DZ, `LMXT_OP_MOV_DO:
      begin
        o_bytes  = by_mode(i_src_mode, `LMXT_B_DX_BIN, `LMXT_B_DX_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_DX_BIN, `LMXT_S_DX_SRC);
      end
      `LMXT_OP_MOV_DISP:
      begin
        o_bytes  = by_mode(i_src_mode, `LMXT_B_DISP_BIN, `LMXT_B_DISP_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_DISP_BIN, `LMXT_S_DISP_SRC);
      end
      `LMXT_OP_ST_DW:
      begin
        // Sixteen-bit direct address form, so one byte longer than the short form
        o_bytes  = by_mode(i_src_mode, `LMXT_B_STDW_BIN, `LMXT_B_STDW_SRC);
        o_states = by_mode(i_src_mode, `LMXT_S_STDW_BIN, `LMXT_S_STDW_SRC);
      end
      `LMXT_OP_MOV_DD:
      begin
        o_bytes  = `LMXT_B_DD;
        o_states = `LMXT_S_DD;
      end
      `LMXT_OP_AND_DIR, `LMXT_OP_OR_DIR, `LMXT_OP_XOR_DIR:
      begin
        o_bytes  = `LMXT_B_DIR;
        o_states = `LMXT_S_DIR;
      end
      `LMXT_OP_MOV_LEG_X:
      begin
        o_bytes  = `LMXT_B_LEG;
        o_states = `LMXT_S_LEG;
      end
      default:
      begin
        o_bytes  = `LMXT_B_ACC;
        o_states = `LMXT_S_ACC;
      end
    endcase
  end
endmodule // lmxt_cost

// *** tb/lmxt_exec_props.sv ***
`timescale 1ns/1ps
`include "lmxt_map.vh"
module lmxt_exec_props
#(
  parameter DW = 32
)
(
  // Clock and reset
  input wire          I_CLK_SYS,
  input wire          I_SYS_RST,
  // Request
  input wire          I_SRC_MODE,
  input wire          I_START,
  input wire [4:0]    I_OP,
  input wire [DW-1:0] I_OPND_A,
  // Answer
  input wire          O_BUSY,
  input wire          O_DONE,
  input wire [DW-1:0] O_RESULT,
  input wire [3:0]    O_BYTES,
  input wire [3:0]    O_STATES
);
  reg       up_r;
  reg       md_r;
  reg [3:0] cnt_r;
  // Mode is taken once, at the first edge out of reset
  always @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      up_r  <= 1'b0;
      md_r  <= 1'b0;
      cnt_r <= 4'h0;
    end
    else
    begin
      up_r  <= 1'b1;
      md_r  <= up_r ? md_r : I_SRC_MODE;
      cnt_r <= (O_BUSY && !O_DONE) ? cnt_r + 4'h1 : 4'h0;
    end
  end
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  sequence s_take;
    I_START && !O_BUSY && up_r;
  endsequence
  sequence s_swap;
    O_RESULT[7:0] == {$past(I_OPND_A[3:0]), $past(I_OPND_A[7:4])} ##2 O_DONE;
  endsequence
  a_done_ends_busy: assert property (O_DONE |-> !O_BUSY) else $error("done while busy");
  a_state_count: assert property (O_DONE |-> cnt_r == O_STATES) else $error("bad length");
  a_done_pulse: assert property (O_DONE |=> !O_DONE && (O_BUSY == $past(I_START)))
    else $error("done too long");
  a_start_busy: assert property (s_take |=> O_BUSY) else $error("start lost");
  a_mode_cost: assert property (s_take ##0 I_OP == `LMXT_OP_AND_BR |=> O_STATES == (md_r ? 4'h1 : 4'h2))
    else $error("mode cost");
  a_zero_acc: assert property (s_take ##0 I_OP == `LMXT_OP_ZERO_ACC |=> O_RESULT == 0 ##1 O_DONE)
    else $error("zero acc");
  a_inv_acc: assert property (s_take ##0 I_OP == `LMXT_OP_INV_ACC |=> O_RESULT[7:0] == ~$past(I_OPND_A[7:0]))
    else $error("invert acc");
  a_rotate_one: assert property (s_take ##0 I_OP >= `LMXT_OP_ROL && I_OP <= `LMXT_OP_RORC |=> O_BYTES == 1 ##1 O_DONE)
    else $error("rotate cost");
  a_swap_nib: assert property (s_take ##0 I_OP == `LMXT_OP_SWAP |=> s_swap) else $error("swap");
  a_data_pointer_reg_cost: assert property (s_take ##0 I_OP == `LMXT_OP_LD_PTR |=> O_BYTES == 3 && O_STATES == 2)
    else $error("pointer cost");
endmodule // lmxt_exec_props
bind lmxt_exec lmxt_exec_props #(.DW(DW)) i_props (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
  .I_SRC_MODE(I_SRC_MODE), .I_START(I_START), .I_OP(I_OP), .I_OPND_A(I_OPND_A), .O_BUSY(O_BUSY),
  .O_DONE(O_DONE), .O_RESULT(O_RESULT), .O_BYTES(O_BYTES), .O_STATES(O_STATES));

// *** tb/test_logic_move_exec_timing.sv ***
`timescale 1ns/1ps
`include "lmxt_map.vh"
module test_logic_move_exec_timing;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         sm  = 1'b0;
  reg         go  = 1'b0;
  reg  [4:0]  op  = 5'h00;
  reg         wd  = 1'b0;
  reg  [31:0] a   = 32'h0;
  reg  [31:0] b   = 32'h0;
  reg         ci  = 1'b1;
  reg  [7:0]  da  = 8'h81;
  reg  [15:0] xa  = 16'hbeef;
  reg         pw  = 1'b0;
  reg  [7:0]  pd  = 8'h3c;
  wire        busy, done, co;
  wire [31:0] res;
  wire [3:0]  nb, ns;
  wire [23:0] xo;
  integer     n_errors = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  integer     j;
  integer     k;
  always #2.5 clk = ~clk;
  lmxt_exec #(.DW(32)) i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_SRC_MODE(sm), .I_START(go), .I_OP(op),
    .I_WORD(wd), .I_OPND_A(a), .I_OPND_B(b), .I_CARRY(ci), .I_DIR_ADDR(da), .I_XADDR(xa), .I_PAGE_WR(pw),
    .I_PAGE_DATA(pd), .O_BUSY(busy), .O_DONE(done), .O_RESULT(res), .O_CARRY(co), .O_BYTES(nb),
    .O_STATES(ns), .O_XADDR(xo));
  // ********
  // Helpers
  // ********
  function [3:0] pk(input [3:0] bin, input [3:0] src);
    pk = sm ? src : bin;
  endfunction
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    total_checks = total_checks + 1;
    if (got !== ex)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Result is compared under a mask: unlisted upper bits are left open
  task run(input [4:0] o, input [31:0] x, input [31:0] y, input [3:0] eb, input [3:0] es,
           input [31:0] er, input [31:0] m);
    integer n;
    @(posedge clk) #1;
    op = o;
    a = x;
    b = y;
    go = 1'b1;
    @(posedge clk) #1;
    go = 1'b0;
    chk("busy", 1, busy);
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk) #1;
      n = n + 1;
    end
    chk("time", es, n);
    chk("idle", 0, busy);
    chk("states", es, ns);
    chk("bytes", eb, nb);
    chk("result", er & m, res & m);
  endtask
  function [31:0] lg(input integer s, input [31:0] x, input [31:0] y);
    lg = (s == 0) ? x & y : (s == 1) ? x | y : x ^ y;
  endfunction
  // ********
  // Scenarios
  // ********
  task t_logic;
    for (j = 0; j < 3; j = j + 1)
    begin
      run(`LMXT_OP_AND_BR + j[4:0], 32'h5a3c96c3, 32'h0f0ff0a5, pk(3, 2), pk(2, 1), lg(j, 32'h96c3, 32'hf0a5), 32'hff);
      run(`LMXT_OP_AND_WI + j[4:0], 32'h5a3c96c3, 32'h0f0ff0a5, pk(5, 4), pk(4, 3), lg(j, 32'h96c3, 32'hf0a5), 32'hffff);
      da = 8'h81;
      run(`LMXT_OP_AND_DIR + j[4:0], 32'hc3, 32'ha5, 2, 2, lg(j, 32'hc3, 32'ha5), 32'hff);
      da = 8'ha0;
      run(`LMXT_OP_AND_DIR + j[4:0], 32'hc3, 32'ha5, 2, 4, lg(j, 32'hc3, 32'ha5), 32'hff);
    end
  endtask
  task t_acc;
    run(`LMXT_OP_ZERO_ACC, 32'hffffffff, 0, 1, 1, 0, 32'hffffffff);
    run(`LMXT_OP_INV_ACC, 32'ha5, 0, 1, 1, 32'h5a, 32'hffffffff);
    run(`LMXT_OP_ROL, 32'h96, 0, 1, 1, 32'h2d, 32'hffffffff);
    run(`LMXT_OP_ROLC, 32'h96, 0, 1, 1, 32'h2d, 32'hffffffff);
    chk("carry", 1, co);
    run(`LMXT_OP_ROR, 32'h96, 0, 1, 1, 32'h4b, 32'hffffffff);
    run(`LMXT_OP_RORC, 32'h96, 0, 1, 1, 32'hcb, 32'hffffffff);
    chk("carry", 0, co);
    run(`LMXT_OP_SWAP, 32'ha5, 0, 1, 2, 32'h5a, 32'hff);
  endtask
  task t_shift;
    wd = 1'b0;
    run(`LMXT_OP_ASR, 32'h96, 0, pk(3, 2), pk(2, 1), 32'hcb, 32'hff);
    run(`LMXT_OP_LSR, 32'h96, 0, pk(3, 2), pk(2, 1), 32'h4b, 32'hff);
    run(`LMXT_OP_LSL, 32'h96, 0, pk(3, 2), pk(2, 1), 32'h2c, 32'hff);
    wd = 1'b1;
    run(`LMXT_OP_ASR, 32'h8421, 0, pk(3, 2), pk(2, 1), 32'hc210, 32'hffff);
    run(`LMXT_OP_LSR, 32'h8421, 0, pk(3, 2), pk(2, 1), 32'h4210, 32'hffff);
    run(`LMXT_OP_LSL, 32'h8421, 0, pk(3, 2), pk(2, 1), 32'h0842, 32'hffff);
  endtask
  task t_move;
    for (j = 0; j < 5; j = j + 1)
    begin
      da = (j == 4) ? 8'h81 : 8'h80 + 8'h10 * j[7:0];
      run(`LMXT_OP_MOV_DD, 32'h0, 32'ha5, 3, (j == 4) ? 3 : 4, 32'ha5, 32'hff);
    end
    run(`LMXT_OP_LD_PTR, 0, 32'h1234, 3, 2, 32'h1234, 32'hffff);
    run(`LMXT_OP_MOV_DZ, 0, 32'h8001, pk(5, 4), pk(5, 4), 32'h00008001, 32'hffffffff);
    run(`LMXT_OP_MOV_DO, 0, 32'h8001, pk(5, 4), pk(5, 4), 32'hffff8001, 32'hffffffff);
    run(`LMXT_OP_MOV_DISP, 0, 32'h3c, pk(5, 4), pk(6, 5), 32'h3c, 32'hff);
    run(`LMXT_OP_ST_DW, 0, 32'h12345678, pk(5, 4), pk(7, 6), 32'h12345678, 32'hffffffff);
  endtask
  task t_page;
    run(`LMXT_OP_MOV_LEG_X, 0, 0, 1, 5, 0, 0);
    chk("xaddr", 32'h01beef, {8'h00, xo});
    @(posedge clk) #1;
    pw = 1'b1;
    @(posedge clk) #1;
    pw = 1'b0;
    run(`LMXT_OP_MOV_LEG_X, 0, 0, 1, 5, 0, 0);
    chk("xaddr", 32'h3cbeef, {8'h00, xo});
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      n_errors = n_errors + 1;
      end_of_test;
    end
  end
  // Second reset checks the source opcode mode and the page reset value
  initial
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      rst = 1'b1;
      sm = k[0];
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      t_logic;
      t_acc;
      t_shift;
      t_move;
      t_page;
    end
    end_of_test;
  end
endmodule // test_logic_move_exec_timing
